// *** src/dmc_edge.sv ***
// Rising edge detector for a synchronous input level
module dmc_edge
  import dmc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      rise
);
  typedef struct packed {
    logic last;
  } dmc_edge_s;

  dmc_edge_s st;
  dmc_edge_s next_st;

  always_comb begin
    next_st.last = level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = level & ~st.last;
endmodule

// *** src/dmc_mode_regs.sv ***
// Mode pin, strap decode and serial program registers of the DAC front end
module dmc_mode_regs
  import dmc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       mode_select,
  input  wire dmc_serial_s serial_in,
  input  wire logic       word_length_strap,
  input  wire logic       mute_n,
  output dmc_cfg_s        cfg,
  output logic [7:0]      left_atten_code,
  output logic [7:0]      right_atten_code,
  output logic            format_reserved
);
  typedef struct packed {
    logic [7:0] left_atten_code;
    logic [7:0] right_atten_code;
    logic [7:0] left_active;
    logic [7:0] right_active;
    logic       soft_mute_bit;
    logic       deemph_enable;
    logic       dac_disable;
    logic       word_select_low;
    logic       word_select_high;
    logic       format_select;
    logic       lr_clock_polarity;
    logic       common_atten_select;
    logic       slow_rolloff_select;
    logic       output_invert;
    logic       clock_out_divide;
    logic       deemph_rate_low;
    logic       deemph_rate_high;
    logic       zero_detect_enable;
    dmc_cfg_s   cfg;
    logic       fmt_res;
  } dmc_regs_s;

  dmc_regs_s st;
  dmc_regs_s next_st;

  logic                 shift_rise;
  logic [WORD_BITS-1:0] rx_word;
  logic                 rx_valid;
  logic [1:0]           rx_addr;
  logic                 sw_mode;

  ////////////////////////////////////////////////////////////////////
  // mode select
  assign sw_mode = mode_select;

  dmc_edge u_shift_edge (
    .clock (clock),
    .rst_n (rst_n),
    .level (serial_in.serial_shift_clock),
    .rise  (shift_rise)
  );

  // serial receive, word taken only at latch
  dmc_shifter #(.WIDTH(WORD_BITS)) u_shifter (
    .clock      (clock),
    .rst_n      (rst_n),
    .enable     (sw_mode),
    .shift      (shift_rise),
    .data_bit   (serial_in.serial_data_line),
    .latch      (serial_in.serial_latch_strobe),
    .word       (rx_word),
    .word_valid (rx_valid)
  );

  assign rx_addr = {rx_word[ADDR_HI_POS], rx_word[ADDR_LO_POS]};

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (rx_valid) begin
      case (rx_addr)
        ADDR_LEFT_ATTEN: begin
          next_st.left_atten_code = rx_word[CODE_MSB:0];
          // only a set load bit makes it active
          if (rx_word[LOAD_POS]) begin
            next_st.left_active = rx_word[CODE_MSB:0];
          end
        end
        ADDR_RIGHT_ATTEN: begin
          next_st.right_atten_code = rx_word[CODE_MSB:0];
          if (rx_word[LOAD_POS]) begin
            next_st.right_active = rx_word[CODE_MSB:0];
          end
        end
        ADDR_OUT_WORD: begin
          next_st.soft_mute_bit    = rx_word[R2_MUTE_POS];
          next_st.deemph_enable    = rx_word[R2_DEEMPH_POS];
          next_st.dac_disable      = rx_word[R2_DISABLE_POS];
          next_st.word_select_low  = rx_word[R2_WSEL_LO_POS];
          next_st.word_select_high = rx_word[R2_WSEL_HI_POS];
        end
        ADDR_FMT_FILTER: begin
          next_st.format_select       = rx_word[R3_FMT_POS];
          next_st.lr_clock_polarity   = rx_word[R3_POLARITY_POS];
          next_st.common_atten_select = rx_word[R3_COMMON_POS];
          next_st.slow_rolloff_select = rx_word[R3_ROLLOFF_POS];
          next_st.output_invert       = rx_word[R3_INV_POS];
          next_st.clock_out_divide    = rx_word[R3_CLKDIV_POS];
          next_st.deemph_rate_low     = rx_word[R3_RATE_LO_POS];
          next_st.deemph_rate_high    = rx_word[R3_RATE_HI_POS];
          next_st.zero_detect_enable  = rx_word[R3_ZERO_POS];
        end
        default: begin
          next_st.fmt_res = st.fmt_res;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    if (sw_mode) begin
      // codes pass as attenuation steps of half a dB, 00h mutes
      next_st.cfg.left_atten  = st.left_active;
      // Common control makes the left code drive both channels
      next_st.cfg.right_atten = st.common_atten_select ? st.left_active
                                                        : st.right_active;
      next_st.cfg.soft_mute          = st.soft_mute_bit;
      next_st.cfg.deemph_on          = st.deemph_enable;
      next_st.cfg.deemph_rate        = {st.deemph_rate_high, st.deemph_rate_low};
      next_st.cfg.dac_disable        = st.dac_disable;
      next_st.cfg.word_select        = {st.word_select_high, st.word_select_low};
      next_st.cfg.format_select      = st.format_select;
      next_st.cfg.lr_clock_polarity  = st.lr_clock_polarity;
      next_st.cfg.slow_rolloff       = st.slow_rolloff_select;
      next_st.cfg.output_invert      = st.output_invert;
      next_st.cfg.clock_out_divide   = st.clock_out_divide;
      next_st.cfg.zero_detect_enable = st.zero_detect_enable;
      // format bit with word select 1x is reserved
      next_st.fmt_res = st.format_select & st.word_select_high;
    end else begin
      // straps followed every cycle, other functions fixed
      next_st.cfg.left_atten         = ATTEN_RESET;
      next_st.cfg.right_atten        = ATTEN_RESET;
      next_st.cfg.dac_disable        = 1'b0;
      next_st.cfg.lr_clock_polarity  = 1'b0;
      next_st.cfg.slow_rolloff       = 1'b0;
      next_st.cfg.output_invert      = 1'b0;
      next_st.cfg.clock_out_divide   = 1'b0;
      next_st.cfg.zero_detect_enable = 1'b0;
      // de-emphasis straps share the shift clock and data pins
      next_st.cfg.deemph_rate = {serial_in.serial_shift_clock, serial_in.serial_data_line};
      next_st.cfg.deemph_on   = serial_in.serial_shift_clock | serial_in.serial_data_line;
      next_st.cfg.soft_mute = ~mute_n;
      // latch pin is the I2S strap; I2S with long word means 24-bit I2S
      next_st.cfg.format_select = serial_in.serial_latch_strobe;
      next_st.cfg.word_select   = {1'b0, word_length_strap};
      next_st.fmt_res           = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st                  <= '0;
      st.left_atten_code  <= ATTEN_RESET;
      st.right_atten_code <= ATTEN_RESET;
      st.left_active      <= ATTEN_RESET;
      st.right_active     <= ATTEN_RESET;
      st.deemph_rate_high <= RATE_RESET[1];
      st.deemph_rate_low  <= RATE_RESET[0];
      st.cfg.left_atten   <= ATTEN_RESET;
      st.cfg.right_atten  <= ATTEN_RESET;
      st.cfg.deemph_rate  <= RATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cfg              = st.cfg;
  assign left_atten_code  = st.left_atten_code;
  assign right_atten_code = st.right_atten_code;
  assign format_reserved  = st.fmt_res;

  ////////////////////////////////////////////////////////////////////
  chk_load_gates_left: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_LEFT_ATTEN && !rx_word[LOAD_POS]
      |=> $stable(st.left_active))
    else $error("left attenuation changed without load bit");
  chk_load_takes_left: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_LEFT_ATTEN && rx_word[LOAD_POS]
      |=> st.left_active == $past(rx_word[CODE_MSB:0]))
    else $error("left attenuation not loaded");
  chk_load_takes_right: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_RIGHT_ATTEN && rx_word[LOAD_POS]
      |=> st.right_active == $past(rx_word[CODE_MSB:0]))
    else $error("right attenuation not loaded");
  chk_reg2_mute: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_OUT_WORD && sw_mode
      |=> ##1 cfg.soft_mute == $past(rx_word[R2_MUTE_POS], 2))
    else $error("mute bit not applied");
  chk_reg3_zero: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_FMT_FILTER && sw_mode
      |=> ##1 cfg.zero_detect_enable == $past(rx_word[R3_ZERO_POS], 2))
    else $error("zero detect bit not applied");
  chk_hw_mute_pin: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> cfg.soft_mute == !$past(mute_n))
    else $error("hardware mute pin not followed");
  chk_hw_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> cfg.left_atten == ATTEN_RESET && !cfg.dac_disable)
    else $error("hardware mode fixed settings wrong");
  chk_hw_deemph: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select && !serial_in.serial_shift_clock && !serial_in.serial_data_line
      |=> !cfg.deemph_on)
    else $error("de-emphasis not off for LL straps");
  chk_hw_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> !rx_valid)
    else $error("serial word taken in hardware mode");
  chk_load_gates_right: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_RIGHT_ATTEN && !rx_word[LOAD_POS]
      |=> $stable(st.right_active))
    else $error("right attenuation changed without load bit");
  chk_code_left: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_LEFT_ATTEN
      |=> left_atten_code == $past(rx_word[CODE_MSB:0]))
    else $error("left code not stored");
  chk_code_right: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_RIGHT_ATTEN
      |=> right_atten_code == $past(rx_word[CODE_MSB:0]))
    else $error("right code not stored");
  chk_addr_left: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr != ADDR_LEFT_ATTEN
      |=> $stable(left_atten_code))
    else $error("left code written by another address");
  chk_addr_right: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr != ADDR_RIGHT_ATTEN
      |=> $stable(right_atten_code))
    else $error("right code written by another address");
  chk_latch_only: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_valid |=> $stable(left_atten_code) && $stable(right_atten_code))
    else $error("code changed without a latch");
  chk_reg2_deemph: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_OUT_WORD && sw_mode
      |=> ##1 cfg.deemph_on == $past(rx_word[R2_DEEMPH_POS], 2))
    else $error("de-emphasis bit not applied");
  chk_reg2_word: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_OUT_WORD && sw_mode
      |=> ##1 cfg.dac_disable == $past(rx_word[R2_DISABLE_POS], 2)
        && cfg.word_select == $past(rx_word[R2_WSEL_HI_POS:R2_WSEL_LO_POS], 2))
    else $error("operation or word select not applied");
  chk_reg3_rate: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && rx_addr == ADDR_FMT_FILTER && sw_mode
      |=> ##1 cfg.deemph_rate == $past(rx_word[R3_RATE_HI_POS:R3_RATE_LO_POS], 2))
    else $error("de-emphasis rate not applied");
  chk_common_atten: assert property (@(posedge clock) disable iff (!rst_n)
    sw_mode && st.common_atten_select |=> cfg.right_atten == cfg.left_atten)
    else $error("common attenuation not shared");
  chk_reserved_code: assert property (@(posedge clock) disable iff (!rst_n)
    sw_mode |=> format_reserved == (cfg.format_select && cfg.word_select[1]))
    else $error("reserved format flag wrong");
  chk_hw_format: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> cfg.format_select == $past(serial_in.serial_latch_strobe)
      && cfg.word_select == {1'b0, $past(word_length_strap)} && !format_reserved)
    else $error("hardware format straps not followed");
  chk_hw_rate: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> cfg.deemph_rate
      == {$past(serial_in.serial_shift_clock), $past(serial_in.serial_data_line)})
    else $error("hardware de-emphasis rate not followed");
  chk_hw_fixed_rest: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_select |=> cfg.right_atten == ATTEN_RESET && !cfg.zero_detect_enable
      && !cfg.lr_clock_polarity && !cfg.slow_rolloff && !cfg.output_invert
      && !cfg.clock_out_divide)
    else $error("hardware mode filter or output settings moved");
  chk_reset_defaults: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> !cfg.soft_mute && !cfg.deemph_on && !cfg.format_select
      && cfg.word_select == WSEL_RESET && !cfg.lr_clock_polarity)
    else $error("format or mute default wrong after reset");
  chk_reset_filter: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> cfg.left_atten == ATTEN_RESET && cfg.right_atten == ATTEN_RESET
      && cfg.deemph_rate == RATE_RESET && !cfg.dac_disable && !cfg.zero_detect_enable
      && !cfg.slow_rolloff && !cfg.output_invert && !cfg.clock_out_divide)
    else $error("attenuation or filter default wrong after reset");
endmodule

// *** src/dmc_pkg.sv ***
// Shared constants and types for the DAC mode control front end
package dmc_pkg;
  localparam int unsigned WORD_BITS = 16;

  // Serial word field positions
  localparam int unsigned ADDR_HI_POS = 10;
  localparam int unsigned ADDR_LO_POS = 9;
  localparam int unsigned LOAD_POS    = 8;
  localparam int unsigned CODE_MSB    = 7;

  // Register addresses
  localparam logic [1:0] ADDR_LEFT_ATTEN  = 2'h0;
  localparam logic [1:0] ADDR_RIGHT_ATTEN = 2'h1;
  localparam logic [1:0] ADDR_OUT_WORD    = 2'h2;
  localparam logic [1:0] ADDR_FMT_FILTER  = 2'h3;

  // Register 2 fields
  localparam int unsigned R2_MUTE_POS  = 0;
  localparam int unsigned R2_DEEMPH_POS = 1;
  localparam int unsigned R2_DISABLE_POS = 2;
  localparam int unsigned R2_WSEL_LO_POS = 3;
  localparam int unsigned R2_WSEL_HI_POS = 4;

  // Register 3 fields
  localparam int unsigned R3_FMT_POS      = 0;
  localparam int unsigned R3_POLARITY_POS = 1;
  localparam int unsigned R3_COMMON_POS   = 2;
  localparam int unsigned R3_ROLLOFF_POS  = 3;
  localparam int unsigned R3_INV_POS      = 4;
  localparam int unsigned R3_CLKDIV_POS   = 5;
  localparam int unsigned R3_RATE_LO_POS  = 6;
  localparam int unsigned R3_RATE_HI_POS  = 7;
  localparam int unsigned R3_ZERO_POS     = 8;

  // Reset values
  localparam logic [7:0] ATTEN_RESET     = 8'hff;
  localparam logic [1:0] RATE_RESET      = 2'h2;
  localparam logic [1:0] RATE_OFF        = 2'h0;
  localparam logic [1:0] WSEL_RESET      = 2'h0;

  // Effective audio interface settings
  typedef struct packed {
    logic [7:0] left_atten;
    logic [7:0] right_atten;
    logic       soft_mute;
    logic       deemph_on;
    logic [1:0] deemph_rate;
    logic       dac_disable;
    logic [1:0] word_select;
    logic       format_select;
    logic       lr_clock_polarity;
    logic       slow_rolloff;
    logic       output_invert;
    logic       clock_out_divide;
    logic       zero_detect_enable;
  } dmc_cfg_s;

  // Serial strobes as seen by the shifter
  typedef struct packed {
    logic serial_latch_strobe;
    logic serial_shift_clock;
    logic serial_data_line;
  } dmc_serial_s;
endpackage

// *** src/dmc_shifter.sv ***
// Sixteen bit serial receiver for the program word
module dmc_shifter
  import dmc_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_BITS
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             shift,
  input  wire logic             data_bit,
  input  wire logic             latch,
  output logic [WIDTH-1:0]      word,
  output logic                  word_valid
);
  typedef struct packed {
    logic [WIDTH-1:0] shreg;
    logic [WIDTH-1:0] word;
    logic             valid;
  } dmc_shifter_s;

  dmc_shifter_s st;
  dmc_shifter_s next_st;

  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    if (enable && shift) begin
      // MSB first, so older bits move up
      next_st.shreg = {st.shreg[WIDTH-2:0], data_bit};
    end
    if (enable && latch) begin
      next_st.word  = st.shreg;
      next_st.valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word       = st.word;
  assign word_valid = st.valid;
endmodule

// *** verification/dmc_host_model.sv ***
// Host controller model driving the serial control lines and strap pins
module dmc_host_model
  import dmc_pkg::*;
(
  input  wire logic  clock,
  output dmc_serial_s serial_out,
  output logic        word_length_strap,
  output logic        mute_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_out        = 3'b001;
    word_length_strap = 1'b0;
    mute_n            = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // three lines, MSB first
  // sixteen bits then one latch pulse when do_latch is set
  task automatic send_word(input logic [15:0] w, input logic do_latch);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clock);
      serial_out.serial_data_line   = w[i];
      serial_out.serial_shift_clock = 1'b0;
      @(negedge clock);
      serial_out.serial_shift_clock = 1'b1;
      @(negedge clock);
      serial_out.serial_shift_clock = 1'b0;
    end
    @(negedge clock);
    serial_out.serial_latch_strobe = do_latch;
    @(negedge clock);
    serial_out.serial_latch_strobe = 1'b0;
    // Released data line floats to its pull-up level
    serial_out.serial_data_line = 1'b1;
  endtask

  task automatic write_reg(input logic [1:0] addr, input logic [8:0] payload,
                           input logic do_latch);
    send_word({5'h00, addr, payload}, do_latch);
  endtask

  // Strap levels share the serial pins in hardware control
  task automatic set_straps(input logic hi, input logic lo, input logic i2s,
                            input logic wl, input logic mute);
    @(negedge clock);
    serial_out        = {i2s, hi, lo};
    word_length_strap = wl;
    mute_n            = mute;
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the DAC mode control front end
module testbench
  import dmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock;
  logic        rst_n;
  logic        mode_select;
  dmc_serial_s serial_in;
  logic        word_length_strap;
  logic        mute_n;
  dmc_cfg_s    cfg;
  logic [7:0]  left_atten_code;
  logic [7:0]  right_atten_code;
  logic        format_reserved;
  int          fail_count;
  int          n_tests;
  dmc_cfg_s    exp_cfg;

  dmc_host_model host (
    .clock             (clock),
    .serial_out        (serial_in),
    .word_length_strap (word_length_strap),
    .mute_n            (mute_n)
  );

  dmc_mode_regs uut (
    .clock             (clock),
    .rst_n             (rst_n),
    .mode_select       (mode_select),
    .serial_in         (serial_in),
    .word_length_strap (word_length_strap),
    .mute_n            (mute_n),
    .cfg               (cfg),
    .left_atten_code   (left_atten_code),
    .right_atten_code  (right_atten_code),
    .format_reserved   (format_reserved)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_tests++;
    if (seen !== expected) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic check_cfg();
    check({3'h0, cfg}, {3'h0, exp_cfg});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic dmc_cfg_s dflt();
    dmc_cfg_s d;
    d             = '0;
    d.left_atten  = ATTEN_RESET;
    d.right_atten = ATTEN_RESET;
    d.deemph_rate = RATE_RESET;
    return d;
  endfunction

  // Settings reach cfg three clocks after the latch
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    exp_cfg = dflt();
    check_cfg();
    check(32'(right_atten_code), 32'hff);
  endtask

  task automatic t_atten();
    host.write_reg(ADDR_LEFT_ATTEN, 9'h080, 1'b0);
    settle();
    check(32'(left_atten_code), 32'hff);
    host.write_reg(ADDR_LEFT_ATTEN, 9'h080, 1'b1);
    settle();
    check(32'(left_atten_code), 32'h80);
    check_cfg();
    host.write_reg(ADDR_LEFT_ATTEN, 9'h1fe, 1'b1);
    settle();
    exp_cfg.left_atten = 8'hfe;
    check_cfg();
    host.write_reg(ADDR_RIGHT_ATTEN, 9'h100, 1'b1);
    settle();
    exp_cfg.right_atten = 8'h00;
    check(32'(right_atten_code), 32'h00);
    check_cfg();
    host.write_reg(ADDR_RIGHT_ATTEN, 9'h033, 1'b1);
    settle();
    check(32'(right_atten_code), 32'h33);
    check_cfg();
  endtask

  task automatic t_reg2();
    host.write_reg(ADDR_OUT_WORD, 9'h01f, 1'b1);
    settle();
    exp_cfg.soft_mute   = 1'b1;
    exp_cfg.deemph_on   = 1'b1;
    exp_cfg.dac_disable = 1'b1;
    exp_cfg.word_select = 2'h3;
    check_cfg();
    check(32'(format_reserved), 32'h0);
    host.write_reg(ADDR_OUT_WORD, 9'h00a, 1'b1);
    settle();
    exp_cfg.soft_mute   = 1'b0;
    exp_cfg.dac_disable = 1'b0;
    exp_cfg.word_select = 2'h1;
    check_cfg();
  endtask

  task automatic t_reg3();
    host.write_reg(ADDR_FMT_FILTER, 9'h1ff, 1'b1);
    settle();
    exp_cfg.format_select      = 1'b1;
    exp_cfg.lr_clock_polarity  = 1'b1;
    exp_cfg.slow_rolloff       = 1'b1;
    exp_cfg.output_invert      = 1'b1;
    exp_cfg.clock_out_divide   = 1'b1;
    exp_cfg.deemph_rate        = 2'h3;
    exp_cfg.zero_detect_enable = 1'b1;
    exp_cfg.right_atten        = 8'hfe;
    check_cfg();
    check(32'(format_reserved), 32'h0);
    host.write_reg(ADDR_OUT_WORD, 9'h010, 1'b1);
    settle();
    exp_cfg.deemph_on   = 1'b0;
    exp_cfg.word_select = 2'h2;
    check_cfg();
    check(32'(format_reserved), 32'h1);
    host.write_reg(ADDR_FMT_FILTER, 9'h0aa, 1'b1);
    settle();
    exp_cfg.format_select      = 1'b0;
    exp_cfg.slow_rolloff       = 1'b1;
    exp_cfg.output_invert      = 1'b0;
    exp_cfg.deemph_rate        = 2'h2;
    exp_cfg.zero_detect_enable = 1'b0;
    exp_cfg.right_atten        = 8'h00;
    check_cfg();
    check(32'(format_reserved), 32'h0);
  endtask

  task automatic t_hardware();
    logic [4:0] v;
    @(negedge clock);
    mode_select = 1'b0;
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      host.set_straps(v[4], v[3], v[2], v[1], v[0]);
      settle();
      exp_cfg               = dflt();
      exp_cfg.deemph_on     = v[4] | v[3];
      exp_cfg.deemph_rate   = v[4:3];
      exp_cfg.format_select = v[2];
      exp_cfg.word_select   = {1'b0, v[1]};
      exp_cfg.soft_mute     = ~v[0];
      check_cfg();
    end
    // Serial traffic while strapped must not reach the registers
    host.write_reg(ADDR_LEFT_ATTEN, 9'h110, 1'b1);
    settle();
    check(32'(left_atten_code), 32'hfe);
  endtask

  // Reset in mid-run must bring back the cfg and left code defaults
  task automatic t_reset();
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    exp_cfg = dflt();
    check_cfg();
    check(32'(left_atten_code), 32'hff);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    rst_n       = 1'b0;
    mode_select = 1'b1;
    fail_count  = 0;
    n_tests     = 0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_defaults();
    t_atten();
    t_reg2();
    t_reg3();
    t_hardware();
    t_reset();
    finish_test();
  end

  // Guard against a hung sequence
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test();
  end
endmodule
